//--- pkg/sfch_pkg.sv
// Shared constants and types of the fieldbus command frame handler.
// Assumes a single core clock domain for the handler and its FIFO.
package sfch_pkg;
    // Frame geometry in bytes.
    localparam int FRAME_LONG = 48;
    localparam int FRAME_SHORT = 32;
    localparam int MAIN_LAST = 31;
    localparam int SUB_FIRST = 32;
    localparam int SUB_LAST = 47;
    // Byte positions inside a frame.
    localparam int IDX_CODE = 0;
    localparam int IDX_WDT = 1;
    localparam int IDX_STAT = 2;
    localparam int IDX_DATA = 4;
    localparam int IDX_HIST = 6;
    // Status byte bit positions.
    localparam int ST_ERR = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_SUB_BAD = 2;
    // Storage sizes.
    localparam int HIST_DEPTH = 4;
    localparam int FIFO_DEPTH = 8;
    // Main command codes.
    localparam logic [7:0] IDLE_COMMAND = 8'h00;
    localparam logic [7:0] PARAM_FETCH_COMMAND = 8'h01;
    localparam logic [7:0] PARAM_STORE_COMMAND = 8'h02;
    localparam logic [7:0] IDENTITY_FETCH_COMMAND = 8'h03;
    localparam logic [7:0] CONFIG_COMMAND = 8'h04;
    localparam logic [7:0] FAULT_REPORT_COMMAND = 8'h05;
    localparam logic [7:0] FAULT_CLEAR_COMMAND = 8'h06;
    // Reset values.
    localparam logic [7:0] WDT_RESET = 8'h00;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [3:0] TICK_RESET = 4'h0;

    typedef enum logic [1:0] {
        PH_WAIT,
        PH_ASYNC,
        PH_SYNC
    } sfch_phase_type;

    typedef enum logic [1:0] {
        RS_IDLE,
        RS_HOLD,
        RS_SEND
    } sfch_resp_type;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } sfch_byte_type;
endpackage

//--- core/sfch_fifo.sv
// Small synchronous FIFO for response bytes.
// Assumes one clock; DEPTH is a power of two.
module sfch_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Fill side.
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side.
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // Full when the pointers differ by the depth, empty when equal.
    assign o_in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_q != rd_q;
    assign o_out_data = mem_q[rd_q[AW-1:0]];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end
endmodule

//--- core/sfch_frame_handler.sv
// Slave-side command frame handler: takes command frames, answers them.
// Assumes frame bytes and link events come from logic on the core clock.
// Behaviour
// - With 48-byte frames, bytes 0 to 31 form the main command area.
// - Bytes 32 to 47 form the secondary area, and only limited pairings are taken; the code refuses every non-idle secondary code.
// - With 32-byte frames there is only the main area and no secondary area.
// - Multi-byte response values go out least significant byte first.
// - The device tracks waiting, asynchronous and synchronous link phases.
// - The communication cycle is a whole multiple of the transmission cycle.
// - In synchronous exchange the answer goes out in the next communication cycle.
// - In synchronous exchange the watchdog is bumped and checked every cycle.
// - In asynchronous exchange the answer may come later and the watchdog is not checked.
// - The identity fetch command returns the motor identity.
// - The configuration command makes the stored settings take effect.
// - The fault report command returns the active alarm and the alarm history.
// - The fault clear command clears the active alarm and erases the history.
module sfch_frame_handler
    import sfch_pkg::*;
#(
    parameter logic [31:0] IDENT_VALUE = 32'h0a0b_0c0d,  // Arbitrary value.
    parameter int FDEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Link setup and events.
    input wire logic i_len48,
    input wire logic [3:0] i_comm_mult,
    input wire logic i_tx_tick,
    input wire logic i_link_connect,
    input wire logic i_link_sync,
    input wire logic i_link_release,
    // Command frame in.
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_last,
    output logic o_rx_ready,
    // Response frame out.
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    output logic o_tx_last,
    input wire logic i_tx_ready,
    // Alarm source.
    input wire logic i_alarm_set,
    input wire logic [11:0] i_alarm_code,
    // Side effects and status.
    output logic o_cfg_apply,
    output logic o_alarm_clear,
    output logic o_wdt_fault,
    output logic o_frame_err,
    output logic [1:0] o_phase
);
    localparam int HW = $clog2(HIST_DEPTH);

    sfch_phase_type phase_q;
    sfch_resp_type state_q;
    sfch_resp_type state_d;
    logic [5:0] rx_idx_q;
    logic rx_over_q;
    logic [7:0] code_q;
    logic [7:0] mwdt_q;
    logic [7:0] sub_code_q;
    logic [7:0] last_mwdt_q;
    logic have_wdt_q;
    logic [7:0] rsp_code_q;
    logic err_q;
    logic sub_bad_q;
    logic [7:0] dwdt_q;
    logic [3:0] tick_cnt_q;
    logic comm_tick_q;
    logic [5:0] resp_idx_q;
    logic alarm_act_q;
    logic [11:0] alarm_cur_q;
    logic [11:0] hist_q [HIST_DEPTH];
    logic [HW-1:0] hist_wr_q;
    logic [HW:0] hist_cnt_q;
    logic rx_ready_q;
    logic tx_valid_q;
    logic [7:0] tx_byte_q;
    logic tx_last_q;
    logic cfg_apply_q;
    logic alarm_clear_q;
    logic wdt_fault_q;
    logic frame_err_q;
    logic [5:0] flen;
    logic rx_take;
    logic accept;
    logic len_ok;
    logic err_d;
    logic clr_now;
    logic push;
    logic push_last;
    logic [7:0] rsp_byte;
    logic [5:0] hoff;
    sfch_byte_type fifo_in;
    sfch_byte_type fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;

    function automatic logic [5:0] len_of(input logic l48);
        len_of = l48 ? 6'(FRAME_LONG) : 6'(FRAME_SHORT);
    endfunction

    function automatic logic [7:0] le_byte(input logic [31:0] w, input logic [1:0] k);
        le_byte = w[{k, 3'h0} +: 8];
    endfunction

    function automatic logic is_known(input logic [7:0] c);
        is_known = (c == IDLE_COMMAND) || (c == IDENTITY_FETCH_COMMAND) ||
            (c == CONFIG_COMMAND) || (c == FAULT_REPORT_COMMAND) ||
            (c == FAULT_CLEAR_COMMAND);
    endfunction

    assign flen = len_of(i_len48);
    assign rx_take = i_rx_valid & rx_ready_q;
    assign accept = rx_take & i_rx_last;
    assign len_ok = (rx_idx_q == flen - 6'h01) && !rx_over_q;
    assign err_d = !len_ok || !is_known(code_q);
    assign clr_now = accept && !err_d && code_q == FAULT_CLEAR_COMMAND;
    assign push = (state_q == RS_SEND) && fifo_in_ready;
    assign push_last = resp_idx_q == flen - 6'h01;
    assign fifo_in = '{last: push_last, data: rsp_byte};
    assign fifo_out_ready = !tx_valid_q || i_tx_ready;
    assign hoff = resp_idx_q - 6'(IDX_HIST);

    assign o_rx_ready = rx_ready_q;
    assign o_tx_valid = tx_valid_q;
    assign o_tx_byte = tx_byte_q;
    assign o_tx_last = tx_last_q;
    assign o_cfg_apply = cfg_apply_q;
    assign o_alarm_clear = alarm_clear_q;
    assign o_wdt_fault = wdt_fault_q;
    assign o_frame_err = frame_err_q;
    assign o_phase = phase_q;

    // Link phase tracking.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_q <= PH_WAIT;
        end else if (i_link_release) begin
            phase_q <= PH_WAIT;
        end else if (phase_q == PH_WAIT && i_link_connect) begin
            phase_q <= PH_ASYNC;
        end else if (phase_q == PH_ASYNC && i_link_sync) begin
            phase_q <= PH_SYNC;
        end
    end

    // Communication cycle from a whole number of transmission ticks.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_q <= TICK_RESET;
            comm_tick_q <= 1'b0;
        end else begin
            comm_tick_q <= 1'b0;
            if (i_tx_tick) begin
                if (i_comm_mult <= 4'h1 || tick_cnt_q >= i_comm_mult - 4'h1) begin
                    tick_cnt_q <= TICK_RESET;
                    comm_tick_q <= 1'b1;
                end else begin
                    tick_cnt_q <= tick_cnt_q + 4'h1;
                end
            end
        end
    end

    // Frame reception and field capture.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_idx_q <= '0;
            rx_over_q <= 1'b0;
            code_q <= CODE_RESET;
            mwdt_q <= WDT_RESET;
            sub_code_q <= CODE_RESET;
        end else if (rx_take) begin
            rx_idx_q <= i_rx_last ? 6'h00 : rx_idx_q + 6'h01;
            if (rx_idx_q == 6'(IDX_CODE)) begin
                rx_over_q <= 1'b0;
                sub_code_q <= CODE_RESET;
                code_q <= i_rx_byte;
            end else if (rx_idx_q == 6'(IDX_WDT)) begin
                mwdt_q <= i_rx_byte;
            end else if (rx_idx_q == 6'(SUB_FIRST) && i_len48) begin
                sub_code_q <= i_rx_byte;
            end
            if (rx_idx_q >= flen - 6'h01 && !i_rx_last) begin
                rx_over_q <= 1'b1;
            end
        end
    end

    // Decode of a whole frame.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rsp_code_q <= CODE_RESET;
            err_q <= 1'b0;
            sub_bad_q <= 1'b0;
            cfg_apply_q <= 1'b0;
            frame_err_q <= 1'b0;
        end else begin
            cfg_apply_q <= accept && !err_d && code_q == CONFIG_COMMAND;
            frame_err_q <= accept && !len_ok;
            if (accept) begin
                rsp_code_q <= code_q;
                err_q <= err_d;
                sub_bad_q <= i_len48 && sub_code_q != IDLE_COMMAND;
            end
        end
    end

    // Watchdog values: own count per cycle, master count checked in sync only.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dwdt_q <= WDT_RESET;
            last_mwdt_q <= WDT_RESET;
            have_wdt_q <= 1'b0;
            wdt_fault_q <= 1'b0;
        end else begin
            wdt_fault_q <= 1'b0;
            if (comm_tick_q) begin
                dwdt_q <= dwdt_q + 8'h01;
            end
            if (phase_q != PH_SYNC) begin
                have_wdt_q <= 1'b0;
            end else if (accept && len_ok) begin
                last_mwdt_q <= mwdt_q;
                have_wdt_q <= 1'b1;
                wdt_fault_q <= have_wdt_q && mwdt_q != last_mwdt_q + 8'h01;
            end
        end
    end

    // Active alarm and history; a new alarm wins over a clear.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alarm_act_q <= 1'b0;
            alarm_cur_q <= '0;
            hist_wr_q <= '0;
            hist_cnt_q <= '0;
            alarm_clear_q <= 1'b0;
        end else begin
            alarm_clear_q <= clr_now;
            if (clr_now) begin
                alarm_act_q <= 1'b0;
                alarm_cur_q <= '0;
                hist_cnt_q <= '0;
            end
            if (i_alarm_set) begin
                alarm_act_q <= 1'b1;
                alarm_cur_q <= i_alarm_code;
                hist_wr_q <= hist_wr_q + 1'b1;
                if (clr_now) begin
                    hist_cnt_q <= (HW+1)'(1);
                end else if (hist_cnt_q != (HW+1)'(HIST_DEPTH)) begin
                    hist_cnt_q <= hist_cnt_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_alarm_set) begin
            hist_q[hist_wr_q] <= i_alarm_code;
        end
    end

    // Responder sequencing.
    always_comb begin
        state_d = state_q;
        case (state_q)
            RS_IDLE: begin
                if (accept) begin
                    state_d = (phase_q == PH_SYNC) ? RS_HOLD : RS_SEND;
                end
            end
            RS_HOLD: begin
                if (comm_tick_q) begin
                    state_d = RS_SEND;
                end
            end
            RS_SEND: begin
                if (push && push_last) begin
                    state_d = RS_IDLE;
                end
            end
            default: begin
                state_d = RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= RS_IDLE;
            resp_idx_q <= '0;
            rx_ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rx_ready_q <= state_d == RS_IDLE;
            if (push) begin
                resp_idx_q <= push_last ? 6'h00 : resp_idx_q + 6'h01;
            end
        end
    end

    // Response byte at the current index, values least significant byte first.
    always_comb begin
        rsp_byte = 8'h00;
        if (resp_idx_q == 6'(IDX_CODE)) begin
            rsp_byte = rsp_code_q;
        end else if (resp_idx_q == 6'(IDX_WDT)) begin
            rsp_byte = dwdt_q;
        end else if (resp_idx_q == 6'(IDX_STAT)) begin
            rsp_byte[ST_ERR] = err_q;
            rsp_byte[ST_ALARM] = alarm_act_q;
            rsp_byte[ST_SUB_BAD] = sub_bad_q;
        end else if (resp_idx_q == 6'(SUB_FIRST)) begin
            rsp_byte = sub_code_q;
        end else if (err_q || resp_idx_q < 6'(IDX_DATA)) begin
            rsp_byte = 8'h00;
        end else if (rsp_code_q == IDENTITY_FETCH_COMMAND && resp_idx_q < 6'(IDX_HIST + 2)) begin
            rsp_byte = le_byte(IDENT_VALUE, resp_idx_q[1:0]);
        end else if (rsp_code_q == FAULT_REPORT_COMMAND && resp_idx_q < 6'(IDX_HIST)) begin
            rsp_byte = le_byte({20'h0, alarm_cur_q}, {1'b0, resp_idx_q[0]});
        end else if (rsp_code_q == FAULT_REPORT_COMMAND &&
                resp_idx_q < 6'(IDX_HIST + 2 * HIST_DEPTH) &&
                (HW+1)'(hoff[5:1]) < hist_cnt_q) begin
            rsp_byte = le_byte({20'h0, hist_q[hist_wr_q - HW'(1) - hoff[HW:1]]},
                {1'b0, hoff[0]});
        end
    end

    sfch_fifo #(
        .WIDTH($bits(sfch_byte_type)),
        .DEPTH(FDEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(state_q == RS_SEND),
        .i_in_data(fifo_in),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out),
        .i_out_ready(fifo_out_ready)
    );

    // Output register stage.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_valid_q <= 1'b0;
            tx_byte_q <= 8'h00;
            tx_last_q <= 1'b0;
        end else if (fifo_out_ready) begin
            tx_valid_q <= fifo_out_valid;
            tx_byte_q <= fifo_out.data;
            tx_last_q <= fifo_out.last;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_cfg_frame;
        accept && len_ok && code_q == CONFIG_COMMAND;
    endsequence

    sequence s_sync_frame;
        accept && phase_q == PH_SYNC && state_q == RS_IDLE;
    endsequence

    sequence s_async_frame;
        accept && phase_q != PH_SYNC && state_q == RS_IDLE;
    endsequence

    AST_CFG_APPLY: assert property (s_cfg_frame |=> o_cfg_apply ##1 !o_cfg_apply)
        else $error("config frame did not give one apply pulse");

    AST_SYNC_HOLD: assert property (s_sync_frame ##1 (!comm_tick_q [*2])
            |-> state_q == RS_HOLD && !push)
        else $error("sync answer left before the next cycle");

    AST_SYNC_GO: assert property (state_q == RS_HOLD && comm_tick_q |=> state_q == RS_SEND)
        else $error("sync answer not started on cycle tick");

    AST_ASYNC_GO: assert property (s_async_frame |=> state_q == RS_SEND)
        else $error("async answer not started");

    AST_NO_WDT_CHECK: assert property (phase_q != PH_SYNC |=> !o_wdt_fault)
        else $error("watchdog fault outside sync exchange");

    AST_WDT_MISMATCH: assert property (phase_q == PH_SYNC && accept && len_ok && have_wdt_q
            && mwdt_q != last_mwdt_q + 8'h01 |=> o_wdt_fault)
        else $error("watchdog mismatch not flagged");

    AST_WDT_BUMP: assert property (comm_tick_q |=> dwdt_q == $past(dwdt_q) + 8'h01)
        else $error("own watchdog not bumped");

    AST_PHASE_UP: assert property (phase_q == PH_WAIT && i_link_connect && !i_link_release
            |=> o_phase == PH_ASYNC)
        else $error("connect did not reach async phase");

    AST_LAST_BYTE: assert property (push && push_last
            |-> resp_idx_q == (i_len48 ? 6'(SUB_LAST) : 6'(MAIN_LAST)))
        else $error("response length wrong");

    AST_ID_LE: assert property (push && !err_q && rsp_code_q == IDENTITY_FETCH_COMMAND
            && resp_idx_q == 6'(IDX_DATA) |-> rsp_byte == IDENT_VALUE[7:0])
        else $error("identity low byte not first");

    AST_UNKNOWN_ERR: assert property (accept && code_q == PARAM_FETCH_COMMAND
            |=> err_q && !o_cfg_apply && !o_alarm_clear)
        else $error("parameter command not refused");

    AST_CLEAR: assert property (accept && len_ok && code_q == FAULT_CLEAR_COMMAND
            && !i_alarm_set |=> !alarm_act_q && hist_cnt_q == '0)
        else $error("fault clear did not clear");
endmodule

//--- verification/sfch_master_model.sv
// Master station model: sends command frames and collects response frames.
// Assumes the handler's byte handshakes run on the same core clock.
module sfch_master_model
    import sfch_pkg::*;
(
    // Clock and control.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_go,
    input wire logic [7:0] i_code,
    input wire logic [7:0] i_wdt,
    input wire logic [7:0] i_sub,
    input wire logic [5:0] i_nbytes,
    input wire logic i_stall,
    output logic o_done,
    output logic [5:0] o_count,
    // Command side.
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_rx_last,
    input wire logic i_rx_ready,
    // Response side.
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_tx_last,
    output logic o_tx_ready
);
    logic [7:0] resp [48];
    logic [5:0] idx_q;
    logic [1:0] slow_q;

    // Main code at byte 0, watchdog at byte 1, secondary code at byte 32.
    function automatic logic [7:0] pick(input logic [5:0] i);
        return (i == 6'h00) ? i_code : (i == 6'h01) ? i_wdt : (i == 6'h20) ? i_sub : 8'h00;
    endfunction

    // Each byte is held until taken; an idle data line toggles.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_valid <= 1'b0;
            o_rx_byte <= 8'h00;
            o_rx_last <= 1'b0;
            idx_q <= 6'h00;
        end else if (i_go) begin
            o_rx_valid <= 1'b1;
            o_rx_byte <= i_code;
            o_rx_last <= (i_nbytes == 6'h01);
            idx_q <= 6'h00;
        end else if (o_rx_valid && i_rx_ready) begin
            o_rx_valid <= !o_rx_last;
            o_rx_byte <= pick(idx_q + 6'h01);
            o_rx_last <= (idx_q + 6'h02 == i_nbytes);
            idx_q <= idx_q + 6'h01;
        end else if (!o_rx_valid) begin
            o_rx_byte <= ~o_rx_byte;
        end
    end

    // Responses are taken every cycle, or one cycle in four while stalling.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slow_q <= 2'h0;
            o_tx_ready <= 1'b0;
            o_done <= 1'b0;
            o_count <= 6'h00;
        end else begin
            slow_q <= slow_q + 2'h1;
            o_tx_ready <= !i_stall || (slow_q == 2'h3);
            if (i_go) begin
                o_done <= 1'b0;
                o_count <= 6'h00;
            end else if (i_tx_valid && o_tx_ready) begin
                resp[o_count] <= i_tx_byte;
                o_count <= o_count + 6'h01;
                o_done <= i_tx_last;
            end
        end
    end
endmodule

//--- verification/servo_fieldbus_command_frame_handler_bench.sv
// Self-checking bench of the command frame handler.
// Assumes the master model on the frame side and a free running tick.
module servo_fieldbus_command_frame_handler_bench
    import sfch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IDENT = 32'h1234_5678;  // Arbitrary value.
    logic clk = 0, rst_n = 0, len48 = 0, tick = 0, conn = 0, sync = 0, rel = 0, aset = 0;
    logic go = 0, stall = 0, done, rxv, rxl, rxr, txv, txl, txr, cfg, clr, wf, fe;
    logic [3:0] tdiv = 4'h0;
    logic [11:0] acode = 12'h000;
    logic [7:0] code = 8'h00, wdt = 8'h00, sub = 8'h00, rxb, txb;
    logic [5:0] nb = 6'h20, cnt;
    logic [1:0] ph;
    int err_total = 0, checks_done = 0, cfg_n = 0, clr_n = 0, wdt_n = 0, fe_n = 0;

    always #5 clk = ~clk;
    // Communication cycle of two transmission cycles of 16 clocks.
    always @(posedge clk) begin
        tdiv <= tdiv + 4'h1;
        tick <= (tdiv == 4'hf);
        cfg_n += (cfg === 1'b1);
        clr_n += (clr === 1'b1);
        wdt_n += (wf === 1'b1);
        fe_n += (fe === 1'b1);
    end

    sfch_frame_handler #(.IDENT_VALUE(IDENT), .FDEPTH(FIFO_DEPTH)) uut (.i_core_clk(clk),
        .i_rst_n(rst_n), .i_len48(len48), .i_comm_mult(4'h2), .i_tx_tick(tick),
        .i_link_connect(conn), .i_link_sync(sync), .i_link_release(rel), .i_rx_valid(rxv),
        .i_rx_byte(rxb), .i_rx_last(rxl), .o_rx_ready(rxr), .o_tx_valid(txv), .o_tx_byte(txb),
        .o_tx_last(txl), .i_tx_ready(txr), .i_alarm_set(aset), .i_alarm_code(acode),
        .o_cfg_apply(cfg), .o_alarm_clear(clr), .o_wdt_fault(wf), .o_frame_err(fe),
        .o_phase(ph));
    sfch_master_model master (.i_core_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_code(code),
        .i_wdt(wdt), .i_sub(sub), .i_nbytes(nb), .i_stall(stall), .o_done(done),
        .o_count(cnt), .o_rx_valid(rxv), .o_rx_byte(rxb), .o_rx_last(rxl), .i_rx_ready(rxr),
        .i_tx_valid(txv), .i_tx_byte(txb), .i_tx_last(txl), .o_tx_ready(txr));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic run(input logic [7:0] c, input logic [7:0] w, input logic [5:0] n);
        int k;
        @(posedge clk);
        go <= 1'b1;
        code <= c;
        wdt <= w;
        nb <= n;
        @(posedge clk);
        go <= 1'b0;
        // The done flag of the previous frame clears only after this edge.
        @(negedge clk);
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (done !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask

    task automatic link(input int which);
        @(posedge clk);
        conn <= (which == 0);
        sync <= (which == 1);
        rel <= (which == 2);
        @(posedge clk);
        {conn, sync, rel} <= 3'b000;
        @(negedge clk);
    endtask

    task automatic t_short();
        run(IDLE_COMMAND, 8'h00, 6'h20);
        chk("length", 8'h20, {2'h0, cnt});
        chk("status", 8'h00, master.resp[2]);
        run(IDENTITY_FETCH_COMMAND, 8'h01, 6'h20);
        chk("echo", IDENTITY_FETCH_COMMAND, master.resp[0]);
        for (int i = 0; i < 4; i++) begin
            chk("ident", IDENT[8*i +: 8], master.resp[4+i]);
        end
    endtask

    task automatic t_codes();
        logic [7:0] bad [3] = '{PARAM_FETCH_COMMAND, PARAM_STORE_COMMAND, 8'h7f};
        foreach (bad[i]) begin
            run(bad[i], 8'h00, 6'h20);
            chk("error status", 8'h01, master.resp[2]);
        end
        chk("no side effect", 8'h00, 8'(cfg_n + clr_n));
        run(CONFIG_COMMAND, 8'h00, 6'h20);
        chk("config pulses", 8'h01, 8'(cfg_n));
    endtask

    task automatic t_alarm();
        @(posedge clk);
        aset <= 1'b1;
        acode <= 12'h9d1;
        @(posedge clk);
        aset <= 1'b0;
        run(FAULT_REPORT_COMMAND, 8'h00, 6'h20);
        chk("alarm status", 8'h02, master.resp[2]);
        chk("active lo", 8'hd1, master.resp[4]);
        chk("active hi", 8'h09, master.resp[5]);
        chk("history lo", 8'hd1, master.resp[6]);
        chk("history hi", 8'h09, master.resp[7]);
        run(FAULT_CLEAR_COMMAND, 8'h00, 6'h20);
        chk("clear pulses", 8'h01, 8'(clr_n));
        run(FAULT_REPORT_COMMAND, 8'h00, 6'h20);
        chk("cleared status", 8'h00, master.resp[2]);
        chk("cleared history", 8'h00, master.resp[6]);
    endtask

    task automatic t_long();
        @(posedge clk);
        len48 <= 1'b1;
        sub <= 8'h2a;
        stall <= 1'b1;
        run(IDLE_COMMAND, 8'h00, 6'h30);
        chk("long length", 8'h30, {2'h0, cnt});
        chk("sub refused", 8'h04, master.resp[2]);
        chk("sub echo", 8'h2a, master.resp[32]);
        run(IDLE_COMMAND, 8'h00, 6'h20);
        chk("length error", 8'h01, {7'h0, master.resp[2][0]});
        chk("frame errors", 8'h01, 8'(fe_n));
        @(posedge clk);
        len48 <= 1'b0;
        sub <= 8'h00;
        stall <= 1'b0;
    endtask

    task automatic t_phase();
        chk("phase", 8'h00, {6'h0, ph});
        link(0);
        chk("phase", 8'h01, {6'h0, ph});
        run(IDLE_COMMAND, 8'h05, 6'h20);
        run(IDLE_COMMAND, 8'h09, 6'h20);
        chk("async wdt", 8'h00, 8'(wdt_n));
        link(1);
        chk("phase", 8'h02, {6'h0, ph});
        run(IDLE_COMMAND, 8'h05, 6'h20);
        chk("sync length", 8'h20, {2'h0, cnt});
        run(IDLE_COMMAND, 8'h06, 6'h20);
        chk("sync wdt ok", 8'h00, 8'(wdt_n));
        run(IDLE_COMMAND, 8'h09, 6'h20);
        chk("sync wdt fault", 8'h01, 8'(wdt_n));
        link(2);
        chk("phase", 8'h00, {6'h0, ph});
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_short();
        t_codes();
        t_alarm();
        t_long();
        t_phase();
        test_done();
    end
endmodule
